// file: dv/pcr_far_pin.sv
// far-side model: the wire of each pad and whoever drives it from outside
module pcr_far_pin
(
  input wire logic clk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last = 3'h0;
  // no pull on the wire: an undriven pad wanders rather than holding
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = ~last[i];
    end
  end
  always @(posedge clk)
    last <= pin_in;
endmodule

// file: dv/tb.sv
// bench for the pad cluster: config port, launch, clear and input paths
`include "pcr_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, ARST_N, CLK_EN, REG_WR, REG_RD;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, rd;
  logic [2:0] ARR_DATAOUT, ARR_OE, ARR_CE_IN, ARR_CE_OUT, ARR_CLK;
  logic [2:0] ARR_ACLR, ARR_SCLR, ARR_DATAIN, ARR_COMB_DATAIN;
  logic [2:0] PIN_IN, PIN_OUT, PIN_OE, ext_en, ext_val;
  logic [5:0] PAD_CLK;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  pcr_cluster #(.CELLS(3), .DCLKS(6)) u_dut
  (
    .SYS_CLK, .ARST_N, .CLK_EN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .ARR_DATAOUT, .ARR_OE, .ARR_CE_IN, .ARR_CE_OUT, .ARR_CLK,
    .ARR_ACLR, .ARR_SCLR, .PAD_CLK, .ARR_DATAIN, .ARR_COMB_DATAIN,
    .PIN_IN, .PIN_OUT, .PIN_OE
  );
  pcr_far_pin u_far
  (
    .clk(SYS_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(PIN_IN)
  );

  initial
  begin
    SYS_CLK = 1'h0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic summarize();
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hung wait ends the run here instead of stalling forever
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [31:0] cfg(input logic [3:0] m, cc, lc, ce, le,
    oe, ac, sc, lv, ir, da, db);
    cfg = {6'h0, db[1:0], da[1:0], ir[0], lv[0], sc[1:0], ac[1:0], oe[1:0],
      le[1:0], ce[1:0], lc, cc, m[1:0]};
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'h0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'h0;
    #1 d = REG_RDATA;
  endtask

  task automatic settle();
    repeat (8) @(posedge SYS_CLK);
    #1;
  endtask

  // pad clocks pass two sync flops, so the pulse is held three cycles
  task automatic tick(input bit pad, input int i);
    @(posedge SYS_CLK);
    if (pad)
      PAD_CLK[i] <= 1'h1;
    else
      ARR_CLK[i] <= 1'h1;
    repeat (3) @(posedge SYS_CLK);
    if (pad)
      PAD_CLK[i] <= 1'h0;
    else
      ARR_CLK[i] <= 1'h0;
    settle();
  endtask

  task automatic t_reset();
    for (int i = 0; i < 3; i++)
    begin
      reg_rd(8'(`PCR_CFG_BASE + i * `PCR_CFG_STRIDE), rd);
      chk_word(rd, 32'(`PCR_CFG_RESET));
    end
    @(posedge SYS_CLK);
    #1 chk_word(REG_RDATA, 32'h0);
    reg_wr(`PCR_STATUS_OFS, 32'hffff_ffff);
    reg_rd(`PCR_STATUS_OFS, rd);
    chk_word(rd, 32'h0);
    reg_rd(8'h10, rd);
    chk_word(rd, 32'h0);
    chk_word(32'(PIN_OE), 32'h0);
  endtask

  task automatic t_launch();
    @(posedge SYS_CLK);
    ARR_CE_OUT[0] <= 1'h1;
    ARR_OE[0] <= 1'h1;
    ARR_DATAOUT[0] <= 1'h1;
    reg_wr(8'h00, cfg(2, 15, 0, 3, 0, 0, 3, 3, 0, 0, 0, 0));
    settle();
    chk_bit(PIN_OE[0], 1'h0);
    tick(0, 0);
    chk_bit(PIN_OUT[0], 1'h1);
    chk_bit(PIN_OE[0], 1'h1);
    chk_bit(PIN_IN[0], 1'h1);
    @(posedge SYS_CLK);
    ARR_CE_OUT[0] <= 1'h0;
    ARR_OE[0] <= 1'h0;
    ARR_DATAOUT[0] <= 1'h0;
    tick(0, 0);
    chk_bit(PIN_OUT[0], 1'h1);
    chk_bit(PIN_OE[0], 1'h1);
    @(posedge SYS_CLK);
    ARR_CE_OUT[0] <= 1'h1;
    tick(0, 0);
    chk_bit(PIN_OUT[0], 1'h0);
    chk_bit(PIN_OE[0], 1'h0);
  endtask

  task automatic t_clear();
    reg_wr(8'h04, cfg(1, 15, 1, 3, 3, 3, 1, 1, 1, 0, 0, 0));
    settle();
    chk_bit(PIN_OUT[1], 1'h1);
    chk_bit(PIN_OE[1], 1'h1);
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h0);
    @(posedge SYS_CLK);
    ARR_SCLR[1] <= 1'h1;
    settle();
    chk_bit(PIN_OUT[1], 1'h0);
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h1);
    @(posedge SYS_CLK);
    ARR_SCLR[1] <= 1'h0;
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h0);
    @(posedge SYS_CLK);
    ARR_ACLR[1] <= 1'h1;
    settle();
    chk_bit(PIN_OUT[1], 1'h1);
    chk_bit(PIN_OUT[0], 1'h0);
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h1);
    reg_rd(`PCR_STATUS_OFS, rd);
    chk_bit(rd[4], 1'h1);
    chk_bit(rd[7], 1'h1);
    @(posedge SYS_CLK);
    ARR_ACLR[1] <= 1'h0;
  endtask

  // a frozen cluster must ignore ticks and config writes alike
  task automatic t_hold();
    @(posedge SYS_CLK);
    CLK_EN <= 1'h0;
    reg_wr(8'h04, 32'h0);
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h1);
    @(posedge SYS_CLK);
    CLK_EN <= 1'h1;
    reg_rd(8'h04, rd);
    chk_word(rd, cfg(1, 15, 1, 3, 3, 3, 1, 1, 1, 0, 0, 0));
    tick(0, 1);
    chk_bit(PIN_OUT[1], 1'h0);
  endtask

  task automatic t_input();
    @(posedge SYS_CLK);
    ext_en[2] <= 1'h1;
    ext_val[2] <= 1'h1;
    reg_wr(8'h08, cfg(0, 3, 15, 3, 3, 3, 3, 3, 0, 1, 0, 0));
    settle();
    chk_bit(PIN_OE[2], 1'h0);
    chk_bit(ARR_COMB_DATAIN[2], 1'h1);
    chk_bit(ARR_DATAIN[2], 1'h0);
    tick(1, 0);
    chk_bit(ARR_DATAIN[2], 1'h1);
    @(posedge SYS_CLK);
    ext_val[2] <= 1'h0;
    tick(0, 0);
    chk_bit(ARR_COMB_DATAIN[2], 1'h0);
    chk_bit(ARR_DATAIN[2], 1'h1);
    @(posedge SYS_CLK);
    ext_val[2] <= 1'h1;
    reg_wr(8'h08, cfg(0, 3, 15, 3, 3, 3, 3, 3, 0, 1, 1, 2));
    tick(1, 0);
    reg_rd(`PCR_STATUS_OFS, rd);
    chk_bit(rd[14], 1'h1);
    chk_bit(rd[2], 1'h0);
    chk_bit(ARR_DATAIN[2], 1'h1);
    chk_bit(ARR_COMB_DATAIN[2], 1'h1);
  endtask

  initial
  begin
    ARST_N = 1'h0;
    CLK_EN = 1'h1;
    REG_WR = 1'h0;
    REG_RD = 1'h0;
    REG_ADDR = 8'h00;
    REG_WDATA = 32'h0;
    {ARR_DATAOUT, ARR_OE, ARR_CE_OUT, ARR_CLK, ARR_ACLR, ARR_SCLR} = 18'h0;
    ARR_CE_IN = 3'h7;
    PAD_CLK = 6'h00;
    // outside drivers hold every pad low until the cell takes it over
    ext_en = 3'h7;
    ext_val = 3'h0;
    repeat (10) @(posedge SYS_CLK);
    ARST_N <= 1'h1;
    t_reset();
    t_launch();
    t_clear();
    t_hold();
    t_input();
    summarize();
  end
endmodule

// file: hdl/pcr_cluster.sv
// pad cluster: shared control selection, config port and three pad cells
//
// Added by the designer: the plain strobed port and the register addresses.
`include "pcr_regs.svh"
module pcr_cluster
#(
  parameter int CELLS = 3,
  parameter int DCLKS = 6
)
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [`PCR_ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [CELLS-1:0] ARR_DATAOUT,
  input wire logic [CELLS-1:0] ARR_OE,
  input wire logic [CELLS-1:0] ARR_CE_IN,
  input wire logic [CELLS-1:0] ARR_CE_OUT,
  input wire logic [CELLS-1:0] ARR_CLK,
  input wire logic [CELLS-1:0] ARR_ACLR,
  input wire logic [CELLS-1:0] ARR_SCLR,
  input wire logic [DCLKS-1:0] PAD_CLK,
  output logic [CELLS-1:0] ARR_DATAIN,
  output logic [CELLS-1:0] ARR_COMB_DATAIN,
  input wire logic [CELLS-1:0] PIN_IN,
  output logic [CELLS-1:0] PIN_OUT,
  output logic [CELLS-1:0] PIN_OE
);

  localparam int NSRC = CELLS + DCLKS;

  typedef struct packed
  {
    logic [CELLS-1:0][`PCR_CFG_W-1:0] cfg;
    logic [CELLS-1:0] init;
    logic [31:0] rdata;
    logic [CELLS-1:0] pin_s1;
    logic [CELLS-1:0] pin_s2;
    logic [DCLKS-1:0] dclk_s1;
    logic [DCLKS-1:0] dclk_s2;
    logic [DCLKS-1:0] dclk_d;
    logic [CELLS-1:0] cclk_d;
  } pcr_top_state_type;

  localparam pcr_top_state_type TOP_RESET = '{
    cfg: {CELLS{`PCR_CFG_RESET}},
    default: '0
  };

  pcr_top_state_type s;
  pcr_top_state_type next_s;

  logic [NSRC-1:0] src_rise;
  logic [CELLS-1:0] cap_q;
  logic [CELLS-1:0] lau_q;
  logic [CELLS-1:0] oe_q;
  logic [CELLS-1:0] no_cap;
  logic [5*CELLS-1:0] status;

  function automatic logic [`PCR_ADDR_W-1:0] cfg_addr(input int idx);
    cfg_addr = `PCR_CFG_BASE + `PCR_ADDR_W'(idx * `PCR_CFG_STRIDE);
  endfunction

  // array clocks are same-domain logic; pad clocks come off the global
  // network and are synchronised first, so they tick two cycles later
  assign src_rise = {s.dclk_s2 & ~s.dclk_d, ARR_CLK & ~s.cclk_d};

  assign status = {no_cap, s.pin_s2, oe_q, lau_q, cap_q};

  always_comb
  begin
    next_s = s;
    next_s.init = '0;
    next_s.rdata = '0;
    next_s.pin_s1 = PIN_IN;
    next_s.pin_s2 = s.pin_s1;
    next_s.dclk_s1 = PAD_CLK;
    next_s.dclk_s2 = s.dclk_s1;
    next_s.dclk_d = s.dclk_s2;
    next_s.cclk_d = ARR_CLK;
    for (int i = 0; i < CELLS; i++)
    begin
      if (REG_WR && (REG_ADDR == cfg_addr(i)))
      begin
        next_s.cfg[i] = REG_WDATA[`PCR_CFG_W-1:0];
        // a config write counts as configuration done for that cell
        next_s.init[i] = 1'b1;
      end
      if (REG_RD && (REG_ADDR == cfg_addr(i)))
        next_s.rdata = 32'(s.cfg[i]);
    end
    if (REG_RD && (REG_ADDR == `PCR_STATUS_OFS))
      next_s.rdata = 32'(status);
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      s <= TOP_RESET;
    else if (CLK_EN)
      s <= next_s;
  end

  assign REG_RDATA = s.rdata;

  for (genvar g = 0; g < CELLS; g++)
  begin : g_cell
    logic [3:0] capclk_sel;
    logic [3:0] lauclk_sel;
    logic [1:0] capce_sel;
    logic [1:0] lauce_sel;
    logic [1:0] oe_sel;
    logic [1:0] aclr_sel;
    logic [1:0] sclr_sel;
    logic [1:0] dly_a;
    logic [1:0] dly_b;
    logic cap_tick;
    logic lau_tick;
    logic cap_ce;
    logic lau_ce;
    logic d_oe;
    logic aclr;
    logic sclr;

    assign capclk_sel = s.cfg[g][`PCR_F_CAPCLK+3:`PCR_F_CAPCLK];
    assign lauclk_sel = s.cfg[g][`PCR_F_LAUCLK+3:`PCR_F_LAUCLK];
    assign capce_sel = s.cfg[g][`PCR_F_CAPCE+1:`PCR_F_CAPCE];
    assign lauce_sel = s.cfg[g][`PCR_F_LAUCE+1:`PCR_F_LAUCE];
    assign oe_sel = s.cfg[g][`PCR_F_OE+1:`PCR_F_OE];
    assign aclr_sel = s.cfg[g][`PCR_F_ACLR+1:`PCR_F_ACLR];
    assign sclr_sel = s.cfg[g][`PCR_F_SCLR+1:`PCR_F_SCLR];
    assign dly_a = s.cfg[g][`PCR_F_DLYA+1:`PCR_F_DLYA];
    assign dly_b = s.cfg[g][`PCR_F_DLYB+1:`PCR_F_DLYB];
    assign no_cap[g] = (dly_a != dly_b);

    // out-of-range selections mean: no clock, enable always on, no clear
    assign cap_tick = (int'(capclk_sel) < NSRC) ?
      src_rise[capclk_sel] : 1'b0;
    assign lau_tick = (int'(lauclk_sel) < NSRC) ?
      src_rise[lauclk_sel] : 1'b0;
    assign cap_ce = (int'(capce_sel) < CELLS) ?
      ARR_CE_IN[capce_sel] : 1'b1;
    assign lau_ce = (int'(lauce_sel) < CELLS) ?
      ARR_CE_OUT[lauce_sel] : 1'b1;
    assign d_oe = (int'(oe_sel) < CELLS) ? ARR_OE[oe_sel] : 1'b1;
    // one selected source feeds every flop, so the cell cannot mix clears
    assign aclr = (int'(aclr_sel) < CELLS) ?
      ARR_ACLR[aclr_sel] : 1'b0;
    assign sclr = (int'(sclr_sel) < CELLS) ?
      ARR_SCLR[sclr_sel] : 1'b0;

    pcr_pad_cell u_cell
    (
      .clk(SYS_CLK),
      .arst_n(ARST_N),
      .clk_en(CLK_EN),
      .mode(pcr_pkg::pcr_mode_type'(s.cfg[g][`PCR_F_MODE+1:`PCR_F_MODE])),
      .level(s.cfg[g][`PCR_F_LEVEL]),
      .in_reg(s.cfg[g][`PCR_F_INREG]),
      .dly_a(dly_a),
      .dly_b(dly_b),
      .init(s.init[g]),
      .aclr(aclr),
      .sclr(sclr),
      .cap_tick(cap_tick),
      .cap_ce(cap_ce),
      .lau_tick(lau_tick),
      .lau_ce(lau_ce),
      .d_out(ARR_DATAOUT[g]),
      .d_oe(d_oe),
      .pin(s.pin_s2[g]),
      .cap_q(cap_q[g]),
      .lau_q(lau_q[g]),
      .oe_q(oe_q[g]),
      .pin_oe(PIN_OE[g]),
      .datain(ARR_DATAIN[g]),
      .comb_datain(ARR_COMB_DATAIN[g])
    );

    // modes 0 and 3 have equal bits and never drive the pad
    property p_in_quiet;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      CLK_EN && (s.cfg[g][`PCR_F_MODE+1] == s.cfg[g][`PCR_F_MODE])
        |=> !PIN_OE[g];
    endproperty
    a_in_quiet: assert property (p_in_quiet)
      else $error("input-only cell drives its pin");

    property p_out_drive;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      CLK_EN && (s.cfg[g][`PCR_F_MODE+1] != s.cfg[g][`PCR_F_MODE])
        |=> PIN_OE[g] == oe_q[g];
    endproperty
    a_out_drive: assert property (p_out_drive)
      else $error("pin drive does not follow the enable flop");

    property p_launch;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      CLK_EN && !s.init[g] && !aclr && lau_tick && lau_ce && !sclr
        |=> lau_q[g] == $past(ARR_DATAOUT[g]);
    endproperty
    a_launch: assert property (p_launch)
      else $error("launch flop missed its data on a launch tick");

    property p_capture;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      CLK_EN && !s.init[g] && !aclr && cap_tick && cap_ce && !sclr
        && !no_cap[g] |=> cap_q[g] == $past(s.pin_s2[g]);
    endproperty
    a_capture: assert property (p_capture)
      else $error("capture flop missed the pad on a capture tick");

    property p_datain;
      @(posedge SYS_CLK) disable iff (!ARST_N)
      CLK_EN && s.cfg[g][`PCR_F_INREG] && !no_cap[g]
        |=> ARR_DATAIN[g] == cap_q[g];
    endproperty
    a_datain: assert property (p_datain)
      else $error("registered input not taken from the capture flop");
  end

  assign PIN_OUT = lau_q;

  property p_cfg_init;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_WR && CLK_EN && (REG_ADDR == `PCR_CFG_BASE)) ##1
      (CLK_EN && !(REG_WR && (REG_ADDR == `PCR_CFG_BASE)))
      |=> (cap_q[0] == s.cfg[0][`PCR_F_LEVEL])
        && (lau_q[0] == s.cfg[0][`PCR_F_LEVEL])
        && (oe_q[0] == s.cfg[0][`PCR_F_LEVEL]);
  endproperty
  a_cfg_init: assert property (p_cfg_init)
    else $error("cell 0 flops not at power-up level after config");

  property p_cfg_read;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REG_RD && CLK_EN && (REG_ADDR == `PCR_CFG_BASE)
      |=> REG_RDATA == 32'($past(s.cfg[0]));
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("cell 0 config read back wrong");

  // the releasing edge still finds the first sync flop held in reset
  property p_pin_sync;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    $past(ARST_N) && CLK_EN ##1 CLK_EN
      |=> s.pin_s2 == $past(PIN_IN, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pin level not two cycles behind the pad");

  property p_dclk_sync;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    $past(ARST_N) && CLK_EN ##1 CLK_EN
      |=> s.dclk_s2 == $past(PAD_CLK, 2);
  endproperty
  a_dclk_sync: assert property (p_dclk_sync)
    else $error("pad clock not two cycles behind its pin");

  property p_rd_idle;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    CLK_EN && !REG_RD |=> REG_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared after the read cycle");

  property p_status_read;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REG_RD && CLK_EN && (REG_ADDR == `PCR_STATUS_OFS)
      |=> REG_RDATA == 32'($past(status));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read back wrong");

  property p_unmapped;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    REG_RD && CLK_EN && (REG_ADDR > `PCR_STATUS_OFS)
      |=> REG_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address read nonzero");

  // enable low must freeze every flop, synchronisers included
  property p_freeze;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !CLK_EN |=> $stable(REG_RDATA) && $stable(PIN_OUT) && $stable(PIN_OE)
      && $stable(ARR_DATAIN) && $stable(ARR_COMB_DATAIN) && $stable(s);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");

endmodule

// file: hdl/pcr_pad_cell.sv
// one pad cell: capture, launch and drive-enable registers, two input paths
`include "pcr_regs.svh"
module pcr_pad_cell
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire pcr_pkg::pcr_mode_type mode,
  input wire logic level,
  input wire logic in_reg,
  input wire logic [1:0] dly_a,
  input wire logic [1:0] dly_b,
  input wire logic init,
  input wire logic aclr,
  input wire logic sclr,
  input wire logic cap_tick,
  input wire logic cap_ce,
  input wire logic lau_tick,
  input wire logic lau_ce,
  input wire logic d_out,
  input wire logic d_oe,
  input wire logic pin,
  output logic cap_q,
  output logic lau_q,
  output logic oe_q,
  output logic pin_oe,
  output logic datain,
  output logic comb_datain
);

  pcr_pkg::pcr_cell_state_type s;
  pcr_pkg::pcr_cell_state_type next_s;
  logic no_cap;
  logic path_a;
  logic oe_d;

  function automatic logic tap(input logic [1:0] sel, input logic now,
                               input logic [`PCR_DLY_W-1:0] hist);
    case (sel)
      2'h0: tap = now;
      2'h1: tap = hist[0];
      2'h2: tap = hist[1];
      default: tap = hist[2];
    endcase
  endfunction

  always_comb
  begin
    next_s = s;
    // unequal taps need the capture flop's silicon for the second chain
    no_cap = (dly_a != dly_b);
    path_a = tap(dly_a, pin, s.dly);
    // a pure output sets its drive enable on every launch without a sync clear
    oe_d = (mode == pcr_pkg::PCR_MODE_OUT) ? 1'b1 : d_oe;
    next_s.dly = {s.dly[`PCR_DLY_W-2:0], pin};
    if (init || aclr)
    begin
      // one clear/preset source and one level for all three flops
      next_s.cap = level;
      next_s.lau = level;
      next_s.oe = level;
    end
    else
    begin
      if (cap_tick && cap_ce && !no_cap)
        next_s.cap = sclr ? level : pin;
      if (lau_tick && lau_ce)
      begin
        next_s.lau = sclr ? level : d_out;
        next_s.oe = sclr ? level : oe_d;
      end
    end
    case (mode)
      pcr_pkg::PCR_MODE_IN: next_s.pin_oe = 1'b0;
      pcr_pkg::PCR_MODE_OUT: next_s.pin_oe = next_s.oe;
      pcr_pkg::PCR_MODE_BIDIR: next_s.pin_oe = next_s.oe;
      default: next_s.pin_oe = 1'b0;
    endcase
    next_s.datain = (in_reg && !no_cap) ? next_s.cap : path_a;
    next_s.comb = tap(dly_b, pin, s.dly);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= `PCR_CELL_RESET;
    else if (clk_en)
      s <= next_s;
  end

  assign cap_q = s.cap;
  assign lau_q = s.lau;
  assign oe_q = s.oe;
  assign pin_oe = s.pin_oe;
  assign datain = s.datain;
  assign comb_datain = s.comb;

  property p_aclr_wins;
    @(posedge clk) disable iff (!arst_n)
    clk_en && aclr |=> (cap_q == $past(level)) && (lau_q == $past(level))
      && (oe_q == $past(level));
  endproperty
  a_aclr_wins: assert property (p_aclr_wins)
    else $error("async clear did not force the power-up level");

  property p_lau_hold;
    @(posedge clk) disable iff (!arst_n)
    clk_en && !init && !aclr && !(lau_tick && lau_ce)
      |=> $stable(lau_q) && $stable(oe_q);
  endproperty
  a_lau_hold: assert property (p_lau_hold)
    else $error("launch or enable flop moved without its enable");

  property p_cap_hold;
    @(posedge clk) disable iff (!arst_n)
    clk_en && !init && !aclr && !(cap_tick && cap_ce) |=> $stable(cap_q);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("capture flop moved without its enable");

  property p_sclr;
    @(posedge clk) disable iff (!arst_n)
    clk_en && !init && !aclr && lau_tick && lau_ce && sclr
      |=> lau_q == $past(level);
  endproperty
  a_sclr: assert property (p_sclr)
    else $error("sync clear ignored on launch edge");

  property p_drive;
    @(posedge clk) disable iff (!arst_n)
    pin_oe |-> oe_q;
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin driven while drive-enable flop inactive");

  property p_nocap;
    @(posedge clk) disable iff (!arst_n)
    clk_en && (dly_a != dly_b) && !init && !aclr |=> $stable(cap_q);
  endproperty
  a_nocap: assert property (p_nocap)
    else $error("capture flop used with split input delays");

  property p_comb_path;
    @(posedge clk) disable iff (!arst_n)
    clk_en && (dly_b == 2'h0) |=> comb_datain == $past(pin);
  endproperty
  a_comb_path: assert property (p_comb_path)
    else $error("bypass path does not follow the pin");

endmodule

// file: hdl/pcr_pkg.sv
// types shared by the pad cluster and its pad cells
`include "pcr_regs.svh"
package pcr_pkg;

  typedef enum logic [1:0]
  {
    PCR_MODE_IN = 2'b00,
    PCR_MODE_OUT = 2'b01,
    PCR_MODE_BIDIR = 2'b10
  } pcr_mode_type;

  typedef struct packed
  {
    logic cap;
    logic lau;
    logic oe;
    logic pin_oe;
    logic datain;
    logic comb;
    logic [`PCR_DLY_W-1:0] dly;
  } pcr_cell_state_type;

endpackage

// file: hdl/pcr_regs.svh
// register offsets, field positions, reset values and widths of the pad cluster
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

`define PCR_ADDR_W 8
`define PCR_CFG_BASE 8'h00
`define PCR_CFG_STRIDE 8'h04
`define PCR_STATUS_OFS 8'h0c

`define PCR_CFG_W 26
`define PCR_F_MODE 0
`define PCR_F_CAPCLK 2
`define PCR_F_LAUCLK 6
`define PCR_F_CAPCE 10
`define PCR_F_LAUCE 12
`define PCR_F_OE 14
`define PCR_F_ACLR 16
`define PCR_F_SCLR 18
`define PCR_F_LEVEL 20
`define PCR_F_INREG 21
`define PCR_F_DLYA 22
`define PCR_F_DLYB 24

`define PCR_CFG_RESET 26'h00f_3ffc
`define PCR_CELL_RESET 9'h000
`define PCR_DLY_W 3

`endif
